// ### bench/test_urs_rx_top.sv
// Purpose: Register-level regression of the serial receive block
// Assumes: Bus accesses run one at a time, and serial frames run one at a time
// Notes  : Short bit time keeps the run brief
`timescale 1ns/100ps
`default_nettype none
module test_urs_rx_top;
    import urs_pkg::*;
    localparam int unsigned BC = 16; // Clocks per serial bit
    logic        sys_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic        rx_pin, irq, tx_go, tx_nine, tx_busy;
    logic [4:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [8:0]  tx_chr;
    logic [1:0]  tx_par, tx_bad;
    logic        e;
    int          failures, compares, cycles;
    urs_rx_top #(.BIT_CYCLES(BC), .DEPTH(FIFO_DEPTH)) DUT (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_pin(rx_pin), .irq(irq));
    urs_tx_model #(.BC(BC)) far_end (
        .sys_clk(sys_clk), .go(tx_go), .chr(tx_chr), .nine(tx_nine),
        .par(tx_par), .bad(tx_bad), .line(rx_pin), .busy(tx_busy));
    // 25 MHz clock
    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;
    // Compare and count
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Verdict and end of run
    task complete_run;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // One Avalon access, held until waitrequest is low
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        // Sample waitrequest at each rising edge; bench ceiling ends hangs
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task rd(input logic [4:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, q, exp);
    endtask : rd
    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    // One frame; optional status look in mid-frame
    task send(input logic [8:0] c, input logic [1:0] b, input bit mid);
        @(posedge sys_clk);
        tx_chr <= c;
        tx_bad <= b;
        tx_go <= 1'b1;
        @(posedge sys_clk);
        tx_go <= 1'b0;
        if (mid) begin
            repeat (40) @(posedge sys_clk);
            rd(OFS_STAT, 32'h20, "busy status");
        end
        do begin
            @(negedge sys_clk);
        end while (tx_busy !== 1'b0);
        repeat (8) @(posedge sys_clk);
    endtask : send
    // Cycle ceiling against hangs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    // Main sequence
    initial begin
        {rst, avs_read, avs_write, tx_go, tx_nine} = 5'h10;
        {avs_address, avs_writedata, tx_chr, tx_par, tx_bad} = '0;
        avs_byteenable = 4'hf;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(OFS_STAT, 32'h10, "reset status");
        rd(OFS_RXD, 32'h0, "reset data");
        rd(5'h18, 32'h0, "unmapped");
        chk("reset irq", irq, 1'b0);
        $display("test reset done");
        wr(OFS_CFG, 32'h1);
        wr(OFS_IRQ_EN, 32'h3);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_STAT, m << 6);
            for (int k = 1; k <= 4; k++) begin
                send(9'h0a0 + 9'(k), 2'h0, 1'b0);
                e = (m < 2) || (m == k - 1);
                rd(OFS_IRQ_STAT, {31'h0, e}, "rx event");
                chk("irq", irq, e);
                wr(OFS_IRQ_CLR, 32'h1);
            end
            if (m == 3) begin
                send(9'h0ff, 2'h0, 1'b0);
                rd(OFS_STAT, 32'hd3, "overrun");
                rd(OFS_IRQ_STAT, 32'h2, "overrun event");
                wr(OFS_STAT, 32'hc0);
                rd(OFS_STAT, 32'hd0, "flushed");
                wr(OFS_STAT, 32'h02);
                rd(OFS_STAT, 32'h10, "no set");
                wr(OFS_IRQ_CLR, 32'h3);
            end else begin
                for (int k = 1; k <= 4; k++) begin
                    rd(OFS_STAT, (m << 6) | 32'h11, "status");
                    rd(OFS_RXD, 32'h0a0 + k, "data");
                end
                rd(OFS_STAT, (m << 6) | 32'h10, "empty");
            end
            $display("test mode %0d done", m);
        end
        wr(OFS_CFG, 32'h5);
        tx_par <= 2'h1;
        send(9'h011, 2'h1, 1'b0);
        send(9'h022, 2'h2, 1'b0);
        send(9'h033, 2'h0, 1'b0);
        rd(OFS_STAT, 32'h19, "parity head");
        rd(OFS_RXD, 32'h11, "data");
        rd(OFS_STAT, 32'h15, "framing head");
        rd(OFS_RXD, 32'h22, "data");
        rd(OFS_STAT, 32'h11, "clean head");
        rd(OFS_RXD, 32'h33, "data");
        wr(OFS_CFG, 32'h9);
        tx_par <= 2'h2;
        send(9'h044, 2'h0, 1'b0);
        rd(OFS_STAT, 32'h11, "odd parity");
        rd(OFS_RXD, 32'h44, "data");
        wr(OFS_IRQ_CLR, 32'h3);
        $display("test errors done");
        wr(OFS_CFG, 32'h3);
        tx_par <= 2'h0;
        tx_nine <= 1'b1;
        wr(OFS_STAT, 32'h20);
        wr(OFS_IRQ_EN, 32'h0);
        send(9'h055, 2'h0, 1'b1);
        rd(OFS_STAT, 32'h30, "dropped");
        rd(OFS_IRQ_STAT, 32'h0, "no event");
        send(9'h1a5, 2'h0, 1'b0);
        rd(OFS_STAT, 32'h31, "address kept");
        chk("masked irq", irq, 1'b0);
        wr(OFS_IRQ_EN, 32'h1);
        @(negedge sys_clk);
        chk("enabled irq", irq, 1'b1);
        rd(OFS_RXD, 32'h1a5, "ninth bit");
        wr(OFS_IRQ_CLR, 32'h1);
        @(negedge sys_clk);
        chk("cleared irq", irq, 1'b0);
        wr(OFS_CFG, 32'h1);
        tx_nine <= 1'b0;
        send(9'h055, 2'h0, 1'b0);
        rd(OFS_STAT, 32'h31, "eight bit");
        rd(OFS_RXD, 32'h55, "data");
        $display("test address done");
        complete_run();
    end
endmodule : test_urs_rx_top
`default_nettype wire

// ### bench/urs_tx_model.sv
// Purpose: Far-end serial transmitter driving the receive line
// Assumes: One start bit, LSB first, one stop bit, BC clocks per bit
// Notes  : bad[0] flips parity, bad[1] sends a low stop bit
`timescale 1ns/100ps
`default_nettype none
module urs_tx_model #(
    parameter int unsigned BC = 16
) (
    input  wire logic       sys_clk,
    input  wire logic       go,
    input  wire logic [8:0] chr,
    input  wire logic       nine,
    input  wire logic [1:0] par,
    input  wire logic [1:0] bad,
    output logic            line,
    output logic            busy
);
    logic [11:0] fr; // Frame bits, start first
    int          n;  // Index of stop bit
    // Line idles high between frames
    initial begin
        line = 1'b1;
        busy = 1'b0;
    end
    // Send one frame per go strobe
    always begin
        @(posedge sys_clk);
        if (go === 1'b1) begin
            busy <= 1'b1;
            n = (nine || par == 2'h1 || par == 2'h2) ? 10 : 9;
            fr = '0;
            fr[8:1] = chr[7:0];
            fr[9] = nine ? chr[8] : (^chr[7:0] ^ (par == 2'h2) ^ bad[0]);
            fr[n] = ~bad[1];
            for (int i = 0; i <= n; i++) begin
                line <= fr[i];
                repeat (BC) @(posedge sys_clk);
            end
            line <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule : urs_tx_model
`default_nettype wire

// ### shared/urs_char_if.sv
// Purpose: Carries one received character into the buffer
// Assumes: Same clock on both ends
// Notes  : valid is a one-cycle push strobe
`timescale 1ns/100ps
`default_nettype none
interface urs_char_if;
    logic       valid;  // Push strobe
    logic [8:0] data;   // Character with ninth bit
    logic       par_err;   // Parity error seen
    logic       frm_err;   // Bad stop bit seen
    modport src (output valid, data, par_err, frm_err);
    modport dst (input  valid, data, par_err, frm_err);
endinterface : urs_char_if
`default_nettype wire

// ### shared/urs_pkg.sv
// Purpose: Shared constants and types of the serial receive block
// Assumes: 25 MHz system clock, 32-bit Avalon-MM register bus
// Notes  : Offsets are byte addresses, one register per word
package urs_pkg;
    // Bit timing: clocks per bit derived from clock and baud rate
    localparam int unsigned CLK_HZ     = 25_000_000;
    localparam int unsigned BAUD_HZ    = 115_200;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_HZ;
    // Receive buffer geometry
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned CHAR_W     = 9;
    // Register byte offsets
    localparam int unsigned ADDR_W     = 5;
    localparam logic [4:0] OFS_STAT     = 5'h00;
    localparam logic [4:0] OFS_RXD      = 5'h04;
    localparam logic [4:0] OFS_CFG      = 5'h08;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h0c;
    localparam logic [4:0] OFS_IRQ_CLR  = 5'h10;
    localparam logic [4:0] OFS_IRQ_EN   = 5'h14;
    // Status and control field positions
    localparam int unsigned BIT_AVAIL  = 0;
    localparam int unsigned BIT_OVR    = 1;
    localparam int unsigned BIT_ADDR_DET = 5;
    localparam int unsigned BIT_ISEL   = 6;
    // Interrupt select codes
    localparam logic [1:0] ISEL_FULL   = 2'h3;
    localparam logic [1:0] ISEL_3Q     = 2'h2;
    // Configuration field positions and parity codes
    localparam int unsigned CFG_EN     = 0;
    localparam int unsigned CFG_NINE   = 1;
    localparam int unsigned CFG_PAR    = 2;
    localparam logic [1:0] PAR_EVEN    = 2'h1;
    localparam logic [1:0] PAR_ODD     = 2'h2;
    // Interrupt event bits
    localparam int unsigned IRQ_RX     = 0;
    localparam int unsigned IRQ_OVR    = 1;
    // Last data bit index for each character size
    localparam logic [3:0] LAST_NINE   = 4'h8;
    localparam logic [3:0] LAST_EIGHT  = 4'h7;
    // Receiver states
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } urs_rx_state_t;
endpackage : urs_pkg

// ### src/urs_rx_fifo.sv
// Purpose: Receive buffer holding characters with their error bits
// Assumes: Caller pushes only when not full, pops only when not empty
// Notes  : Flush wins over push and pop
`timescale 1ns/100ps
`default_nettype none
module urs_rx_fifo #(
    parameter int unsigned DEPTH = urs_pkg::FIFO_DEPTH,
    parameter int unsigned CW    = $clog2(DEPTH + 1)
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          flush,
    urs_char_if.dst            push_if,
    input  wire logic          pop,
    output logic [10:0]        head,
    output logic [CW-1:0]      count
);
    import urs_pkg::*;
    localparam int unsigned PW = $clog2(DEPTH);
    logic [10:0]   mem_q [DEPTH]; // Entries {framing, parity, data}
    logic [PW-1:0] rd_q;          // Head pointer
    logic [PW-1:0] wr_q;          // Tail pointer
    logic [CW-1:0] cnt_q;         // Fill level

    // Storage write port
    always_ff @(posedge sys_clk) begin
        if (push_if.valid && !flush) begin
            mem_q[wr_q] <= {push_if.frm_err, push_if.par_err,
                            push_if.data};
        end
    end

    // Pointers and fill level
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_q  <= '0;
            wr_q  <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            rd_q  <= '0;
            wr_q  <= '0;
            cnt_q <= '0;
        end else begin
            rd_q  <= rd_q + PW'(pop);
            wr_q  <= wr_q + PW'(push_if.valid);
            cnt_q <= cnt_q + CW'(push_if.valid) - CW'(pop);
        end
    end
    // Empty buffer shows a zero head
    assign head  = (cnt_q == '0) ? 11'h000 : mem_q[rd_q];
    assign count = cnt_q;
endmodule : urs_rx_fifo
`default_nettype wire

// ### src/urs_rx_top.sv
// Purpose: Receive status and data path of an asynchronous serial port
// Assumes: Avalon-MM slave with waitrequest, byte addresses
// Notes  : Every access completes one cycle after it is presented
//
// What this block does
// R1: Mode 11 interrupts when buffer becomes full
// R2: Mode 10 interrupts when buffer holds three
// R3: Modes 0x interrupt on every buffered character
// R4: Address mode marks ninth-bit-set characters as addresses
// R5: Address mode acts only in nine-bit configuration
// R6: Idle flag bit 4 shows receiver idle
// R7: Parity flag bit 3 describes head character
// R8: Framing flag bit 2 describes head character
// R9: Overrun bit 1 sets when a character arrives at a full buffer
// R10: Clearing overrun empties buffer and shift register
// R11: Data-available bit 0 shows buffer not empty
// R12: Data register bits 8-0 give head character
// R13: Data register bits 15-9 read zero
// R14: Reading data register removes head character
// R15: Address mode drops characters with ninth bit low
`timescale 1ns/100ps
`default_nettype none
module urs_rx_top #(
    parameter int unsigned BIT_CYCLES = urs_pkg::BIT_CYCLES,
    parameter int unsigned DEPTH      = urs_pkg::FIFO_DEPTH
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic [urs_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic                       rx_pin,
    output logic                            irq
);
    import urs_pkg::*;

    // Derived widths and levels
    localparam int unsigned TW = $clog2(BIT_CYCLES + 1);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [TW-1:0] T_LAST = TW'(BIT_CYCLES - 1);
    localparam logic [TW-1:0] T_HALF = TW'(BIT_CYCLES / 2);
    localparam logic [CW-1:0] LVL_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] LVL_3Q   = CW'(DEPTH * 3 / 4);

    // Synchronised receive line
    logic rx_lvl;

    urs_sync3 u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  (rx_pin),
        .level   (rx_lvl)
    );

    // Software-controlled state
    logic [1:0]  isel_q;      // rx_interrupt_select
    logic        addr_det_q;  // address_detect_enable
    logic        ovr_q;       // overrun_flag
    logic [3:0]  cfg_q;       // Enable, nine-bit, parity select
    logic [1:0]  irq_stat_q;  // Sticky event bits
    logic [1:0]  irq_en_q;    // Event enables
    logic        ack_q;       // Bus answer phase
    logic [31:0] rdata_q;     // Registered read data

    // Configuration decode
    logic       port_en;      // serial_port_enable
    logic       nine;         // Nine-bit characters
    logic [1:0] par_sel;      // Parity mode, eight-bit only
    logic       par_on;       // Parity bit expected
    logic       addr_mode;    // Address detect in effect
    assign port_en   = cfg_q[CFG_EN];
    assign nine      = cfg_q[CFG_NINE];
    assign par_sel   = cfg_q[CFG_PAR +: 2];
    assign par_on    = !nine && (par_sel == PAR_EVEN ||
                                 par_sel == PAR_ODD);
    assign addr_mode = nine && addr_det_q; // see R5

    // Receive shift register state
    urs_rx_state_t st_q, st_d;    // Receiver state
    logic [TW-1:0] tmr_q, tmr_d;  // Bit timer
    logic [3:0]    idx_q, idx_d;  // Data bit index
    logic [8:0]    sh_q, sh_d;    // receive_shift_register
    logic          pe_q, pe_d;    // Parity error of character
    logic          fe_q, fe_d;    // Framing error of character
    logic          done_q, done_d;// Character complete strobe
    logic          tick;          // Timer expiry
    logic [3:0]    last_idx;      // Final data bit index
    logic [8:0]    rx_word;       // Aligned character
    logic          flush;         // Overrun clear event
    assign tick     = (tmr_q == '0);
    assign last_idx = nine ? LAST_NINE : LAST_EIGHT;
    // Eight-bit characters sit in the upper bits after shifting
    assign rx_word  = nine ? sh_q : {1'b0, sh_q[8:1]};

    // Receiver next state
    always_comb begin
        st_d   = st_q;
        tmr_d  = tick ? T_LAST : tmr_q - TW'(1);
        idx_d  = idx_q;
        sh_d   = sh_q;
        pe_d   = pe_q;
        fe_d   = fe_q;
        done_d = 1'b0;
        case (st_q)
            RX_IDLE: begin
                // Wait half a bit to sample mid start bit
                tmr_d = T_HALF;
                idx_d = '0;
                pe_d  = 1'b0;
                if (!rx_lvl) begin
                    st_d = RX_START;
                end
            end
            RX_START: begin
                // A glitch that ends early is ignored
                if (tick) begin
                    st_d = rx_lvl ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                // Least significant bit first
                if (tick) begin
                    sh_d  = {rx_lvl, sh_q[8:1]};
                    idx_d = idx_q + 4'h1;
                    if (idx_q == last_idx) begin
                        st_d = par_on ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                // Compare received parity bit with data
                if (tick) begin
                    pe_d = (par_sel == PAR_EVEN) ?
                           (^rx_word ^ rx_lvl) :
                           !(^rx_word ^ rx_lvl);
                    st_d = RX_STOP;
                end
            end
            RX_STOP: begin
                // Low stop bit marks a framing error
                if (tick) begin
                    fe_d   = !rx_lvl;
                    done_d = 1'b1;
                    st_d   = RX_IDLE;
                end
            end
            default: begin
                st_d = RX_IDLE;
            end
        endcase
        // Disable or overrun clear empties the shift register
        if (!port_en || flush) begin // see R10
            st_d   = RX_IDLE;
            done_d = 1'b0;
        end
    end

    // Receiver registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q   <= RX_IDLE;
            tmr_q  <= '0;
            idx_q  <= '0;
            sh_q   <= '0;
            pe_q   <= 1'b0;
            fe_q   <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            tmr_q  <= tmr_d;
            idx_q  <= idx_d;
            sh_q   <= sh_d;
            pe_q   <= pe_d;
            fe_q   <= fe_d;
            done_q <= done_d;
        end
    end

    // Buffer admission
    logic          drop_addr;  // Data character in address mode
    logic          full;       // Buffer cannot accept
    logic          push;       // Character enters buffer
    logic          ovr_evt;    // Character lost to full buffer
    logic          pop;        // Head removed by read
    logic [CW-1:0] cnt;        // Buffer fill level
    logic [CW-1:0] cnt_after;  // Fill level after this cycle
    logic [10:0]   head;       // {framing, parity, data} of head
    logic          rx_evt;     // Receive interrupt event
    // Ninth bit set is an address, anything else is dropped
    assign drop_addr = addr_mode && !rx_word[8]; // see R4, see R15
    assign full      = (cnt == LVL_FULL);
    assign push      = done_q && !drop_addr && !full && !flush;
    assign ovr_evt   = done_q && !drop_addr && full; // see R9
    assign cnt_after = cnt + CW'(push) - CW'(pop);
    // Interrupt select: full, three quarters or any character
    assign rx_evt = push && (!isel_q[1] ||                 // see R3
                    (isel_q == ISEL_FULL &&
                     cnt_after == LVL_FULL) ||             // see R1
                    (isel_q == ISEL_3Q &&
                     cnt_after == LVL_3Q));                // see R2

    urs_char_if ch_if ();
    assign ch_if.valid = push;
    assign ch_if.data  = rx_word;
    assign ch_if.par_err = pe_q;
    assign ch_if.frm_err = fe_q;

    urs_rx_fifo #(
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk (sys_clk),
        .rst     (rst),
        .flush   (flush),
        .push_if (ch_if.dst),
        .pop     (pop),
        .head    (head),
        .count   (cnt)
    );

    // Bus decode; every access answers on the second cycle
    logic sel_stat, sel_rxd, sel_cfg, sel_ist, sel_iclr, sel_ien;
    logic wr_b0;   // Low byte write completes
    logic rd_fire; // Read completes
    assign sel_stat = (avs_address == OFS_STAT);
    assign sel_rxd  = (avs_address == OFS_RXD);
    assign sel_cfg  = (avs_address == OFS_CFG);
    assign sel_ist  = (avs_address == OFS_IRQ_STAT);
    assign sel_iclr = (avs_address == OFS_IRQ_CLR);
    assign sel_ien  = (avs_address == OFS_IRQ_EN);
    assign wr_b0    = avs_write && ack_q && avs_byteenable[0];
    assign rd_fire  = avs_read && ack_q;
    // Reading the data register consumes the head
    assign pop = rd_fire && sel_rxd && (cnt != '0) && !flush; // see R14
    // Writing zero over a set overrun bit; a new overrun wins
    assign flush = wr_b0 && sel_stat && ovr_q && !ovr_evt &&
                   !avs_writedata[BIT_OVR]; // see R10

    // Read views
    logic        avail;      // rx_data_available
    logic        rx_idle;    // receiver_idle_flag
    logic [7:0]  stat_word;  // serial_status_control
    logic [31:0] rd_mux;     // Selected read word
    logic [1:0]  irq_clr;    // Write-one clear mask
    logic [1:0]  irq_evt;    // Events this cycle
    assign avail   = (cnt != '0);                 // see R11
    assign rx_idle = (st_q == RX_IDLE);           // see R6
    assign stat_word = {isel_q, addr_det_q, rx_idle,
                        head[9],                  // see R7
                        head[10],                 // see R8
                        ovr_q, avail};
    assign rd_mux =
        sel_stat ? 32'(stat_word) :
        sel_rxd  ? 32'(head[8:0]) :               // see R12, see R13
        sel_cfg  ? 32'(cfg_q)     :
        sel_ist  ? 32'(irq_stat_q) :
        sel_ien  ? 32'(irq_en_q)  : 32'h0000_0000;
    assign irq_clr = (wr_b0 && sel_iclr) ? avs_writedata[1:0] : 2'h0;
    assign irq_evt = {ovr_evt, rx_evt};

    // Bus handshake and read data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
            if (avs_read && !ack_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Control registers written by software
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            isel_q   <= 2'h0;
            addr_det_q <= 1'b0;
            cfg_q    <= 4'h0;
            irq_en_q <= 2'h0;
        end else begin
            if (wr_b0 && sel_stat) begin
                isel_q  <= avs_writedata[BIT_ISEL +: 2];
                addr_det_q <= avs_writedata[BIT_ADDR_DET];
            end
            if (wr_b0 && sel_cfg) begin
                cfg_q <= avs_writedata[3:0];
            end
            if (wr_b0 && sel_ien) begin
                irq_en_q <= avs_writedata[1:0];
            end
        end
    end

    // Sticky flags; a new event beats a clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ovr_q      <= 1'b0;
            irq_stat_q <= 2'h0;
        end else begin
            if (ovr_evt) begin
                ovr_q <= 1'b1;                    // see R9
            end else if (flush) begin
                ovr_q <= 1'b0;                    // see R10
            end
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
        end
    end

    assign avs_waitrequest = !ack_q;
    assign avs_readdata    = rdata_q;
    assign irq             = |(irq_stat_q & irq_en_q);

    // Checks on the design's own behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_full_irq_only: assert property ( // see R1
        isel_q == ISEL_FULL && !irq_stat_q[IRQ_RX] &&
        cnt != LVL_FULL - CW'(1) |=> !irq_stat_q[IRQ_RX])
        else $error("full-mode interrupt below full");
    chk_3q_irq_sets: assert property ( // see R2
        push && !pop && isel_q == ISEL_3Q && cnt == LVL_3Q - CW'(1)
        |=> irq_stat_q[IRQ_RX])
        else $error("three-quarter interrupt missing");
    chk_any_irq_sets: assert property ( // see R3
        push && !isel_q[1] |=> irq_stat_q[IRQ_RX])
        else $error("per-character interrupt missing");
    chk_addr_drop: assert property ( // see R15
        done_q && nine && addr_det_q && !rx_word[8] && !flush ##1 1
        |-> cnt == $past(cnt) - CW'($past(pop)))
        else $error("data character entered in address mode");
    chk_idle_leaves: assert property ( // see R6
        st_q == RX_IDLE && !rx_lvl && port_en && !flush
        |=> !rx_idle)
        else $error("idle flag stayed high on start");
    chk_ovr_sticky: assert property ( // see R9
        ovr_evt |=> ovr_q [*2] or (ovr_q ##1 $past(flush)))
        else $error("overrun flag not held");
    chk_flush_empty: assert property ( // see R10
        flush |=> cnt == '0 && st_q == RX_IDLE && !ovr_q)
        else $error("overrun clear did not empty buffer");
    chk_avail_push: assert property ( // see R11
        push |=> avail)
        else $error("data available low after push");
    chk_pop_last: assert property ( // see R14
        pop && !push && cnt == CW'(1) |=> !avail)
        else $error("read did not remove last character");
    chk_rxd_upper: assert property ( // see R13
        rd_fire && sel_rxd |-> avs_readdata[31:9] == '0)
        else $error("receive data upper bits not zero");
    chk_rxd_head: assert property ( // see R12
        avs_read && !ack_q && sel_rxd
        |=> avs_readdata[8:0] == $past(head[8:0]))
        else $error("receive data not head character");
endmodule : urs_rx_top
`default_nettype wire

// ### src/urs_sync3.sv
// Purpose: Three-stage synchroniser for the receive pin
// Assumes: Line idles high
// Notes  : Output moves only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module urs_sync3 (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level
);
    logic s1_q;  // First stage, read only by s2
    logic s2_q;  // Second stage
    logic s3_q;  // Third stage
    logic lvl_q; // Filtered level

    // Shift chain and agreement filter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            s3_q  <= 1'b1;
            lvl_q <= 1'b1;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                lvl_q <= s3_q;
            end
        end
    end
    assign level = lvl_q;
endmodule : urs_sync3
`default_nettype wire
